// file: tbms_pkg.sv
// constants, register map and mode encodings for the tuner bias mode sequencer
`default_nettype none
package tbms_pkg;

  // apb register byte addresses
  localparam logic [11:0] ADDR_BOOST_LEVEL = 12'h000;
  localparam logic [11:0] ADDR_POWER_STATE = 12'h004;
  localparam logic [11:0] ADDR_OUTPUT_ENABLE = 12'h008;
  localparam logic [11:0] ADDR_CODE_A = 12'h00C;
  localparam logic [11:0] ADDR_CODE_B = 12'h010;
  localparam logic [11:0] ADDR_CODE_C = 12'h014;
  localparam logic [11:0] ADDR_STATUS = 12'h018;
  localparam logic [11:0] ADDR_ID = 12'h01C;

  // field widths
  localparam int BOOST_W = 4;
  localparam int PSTATE_W = 2;
  localparam int OUTS = 3;
  localparam int CODE_W = 7;
  localparam int MV_W = 16;

  // reset values
  localparam logic [3:0] BOOST_RST = 4'hB;
  localparam logic [2:0] OUT_EN_RST = 3'h0;
  localparam logic [6:0] CODE_RST = 7'h00;

  // power-state field codes as software sees them
  localparam logic [1:0] PCODE_ACTIVE = 2'h0;
  localparam logic [1:0] PCODE_STARTUP = 2'h1;
  localparam logic [1:0] PCODE_LOWPWR = 2'h2;
  localparam logic [1:0] PCODE_OFF = 2'h3;

  // analog scaling
  localparam logic [15:0] OUT_STEP_MV = 16'h00BD;
  localparam logic [6:0] OUT_FULL_CODE = 7'h7F;
  localparam logic [15:0] RAIL_BASE_MV = 16'h32C8;
  localparam logic [15:0] RAIL_STEP_MV = 16'h03E8;

  // wake-up time from supply rise to active
  localparam int CLK_MHZ = 100;
  localparam int WAKE_TYP_US = 180;
  localparam int WAKE_MAX_US = 300;
  localparam int WAKE_TYP_CYCLES = WAKE_TYP_US * CLK_MHZ;
  localparam int WAKE_MAX_CYCLES = WAKE_MAX_US * CLK_MHZ;
  localparam int WAKE_CNT_W = 16;

  // identity word, value is arbitrary
  localparam logic [31:0] BLOCK_ID = 32'h0000_5A01;

  // status register bit positions
  localparam int ST_MODE_LSB = 0;
  localparam int ST_ARMED_BIT = 2;
  localparam int ST_BOOST_BIT = 3;
  localparam int ST_DRIVE_LSB = 4;

  // internal sequencer states
  typedef enum logic [1:0] {
    MODE_SHUTDOWN = 2'b00,
    MODE_STARTUP = 2'b01,
    MODE_ACTIVE = 2'b10,
    MODE_LOWPWR = 2'b11
  } tbms_mode_e;

endpackage
`default_nettype wire

// file: tbms_sequencer.sv
// operating-mode and power-on-reset sequencer with apb register file
//
// What this block does
// - output code maps linearly, 189 mV per step
// - 4-bit boost level sets rail 13-28 V
// - boost level resets to 1011, 24 V
// - shutdown: all off, outputs high-z, registers lost
// - shutdown at analog power-up and io low
// - io rise: startup, defaults, serial on, boost on
// - startup command from active/low power resets all
// - startup advances to active on its own
// - power field reads 01 then 00
// - outputs off on entry, enable field 000
// - each output programmed and disabled independently
// - low power to active on command
// - active to low power on command
// - low power: serial on, boost off, registers kept
// - io power-on reset also resets serial machine
// - reset fires only on io low-to-high edge
// - shutdown to active within 300 us
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module tbms_sequencer #(
  parameter int WAKE_CYCLES = tbms_pkg::WAKE_TYP_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // supply level indications
  input wire logic analog_supply,
  input wire logic io_supply,
  // controls towards the analog blocks
  output logic boost_enable,
  output logic [3:0] boost_level,
  output logic [15:0] boosted_rail_mv,
  output logic [2:0] out_drive,
  output logic [2:0] out_hiz,
  output logic [6:0] out_code_a,
  output logic [6:0] out_code_b,
  output logic [6:0] out_code_c,
  output logic [15:0] out_mv_a,
  output logic [15:0] out_mv_b,
  output logic [15:0] out_mv_c,
  output logic serial_reset,
  output logic [1:0] power_state
);

  // output code to nominal millivolts
  function automatic logic [15:0] code_to_mv(input logic [6:0] code);
    logic [31:0] prod;
    prod = 32'(code) * 32'(tbms_pkg::OUT_STEP_MV);
    return prod[15:0];
  endfunction

  // boost level code to nominal rail millivolts
  function automatic logic [15:0] level_to_mv(input logic [3:0] lvl);
    logic [31:0] prod;
    prod = 32'(lvl) * 32'(tbms_pkg::RAIL_STEP_MV);
    return prod[15:0] + tbms_pkg::RAIL_BASE_MV;
  endfunction

  localparam logic [15:0] WAKE_LAST =
    16'((WAKE_CYCLES > 1) ? WAKE_CYCLES - 1 : 0);

  // state and registers
  tbms_pkg::tbms_mode_e mode_ff;
  tbms_pkg::tbms_mode_e nxt_mode;
  logic io_prev_ff;
  logic armed_ff;
  logic [15:0] wake_cnt_ff;
  logic [3:0] boost_ff;
  logic [2:0] out_en_ff;
  logic [6:0] code_ff [3];
  logic [31:0] prdata_ff;
  logic serial_reset_ff;
  logic boost_en_ff;
  logic [2:0] drive_ff;
  logic [15:0] rail_mv_ff;
  logic [15:0] mv_ff [3];

  // decode nets
  logic io_rise;
  logic supply_lost;
  logic setup_phase;
  logic wr_take;
  logic addr_ok;
  logic regs_live;
  logic [1:0] pcode;
  logic [1:0] wr_pcode;
  logic cmd_startup;
  logic cmd_lowpwr;
  logic cmd_active;

  // the edge detector needs the level of the previous cycle; a level alone
  // would re-trigger the reset forever while the supply stays high
  always_ff @(posedge clk)
  begin
    if (rst)
      io_prev_ff <= 1'b0;
    else
      io_prev_ff <= io_supply;
  end

  // edge and loss detection on the two supply levels
  assign io_rise = io_supply & ~io_prev_ff;
  assign supply_lost = ~analog_supply | ~io_supply;

  // armed goes low after a power-on reset and only rearms once io drops,
  // so a sagging supply that never crosses low gives no second reset
  always_ff @(posedge clk)
  begin
    if (rst)
      armed_ff <= 1'b1;
    else if (~io_supply)
      armed_ff <= 1'b1;
    else if (io_rise && analog_supply && armed_ff)
      armed_ff <= 1'b0;
  end

  // apb decode; zero wait states, read data caught in the setup cycle
  assign setup_phase = psel & ~penable;
  assign regs_live = (mode_ff == tbms_pkg::MODE_ACTIVE) ||
                     (mode_ff == tbms_pkg::MODE_LOWPWR);
  always_comb
  begin
    unique case (paddr)
      tbms_pkg::ADDR_BOOST_LEVEL, tbms_pkg::ADDR_POWER_STATE,
      tbms_pkg::ADDR_OUTPUT_ENABLE, tbms_pkg::ADDR_CODE_A,
      tbms_pkg::ADDR_CODE_B, tbms_pkg::ADDR_CODE_C,
      tbms_pkg::ADDR_STATUS, tbms_pkg::ADDR_ID:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  end

  // no wait states: every register answers in its first access cycle
  assign pready = 1'b1;
  // the whole chip is unpowered in shutdown, so the bus is refused there
  assign pslverr = psel & penable &
                   (~addr_ok | (mode_ff == tbms_pkg::MODE_SHUTDOWN));
  assign wr_take = psel & penable & pwrite & addr_ok & regs_live;
  assign wr_pcode = pwdata[tbms_pkg::PSTATE_W-1:0];

  // power-state commands legal only from the matching mode; a code that
  // asks for a move not allowed from here is dropped without an error
  assign cmd_startup = wr_take && (paddr == tbms_pkg::ADDR_POWER_STATE) &&
                       (wr_pcode == tbms_pkg::PCODE_STARTUP);
  assign cmd_lowpwr = wr_take && (paddr == tbms_pkg::ADDR_POWER_STATE) &&
                      (wr_pcode == tbms_pkg::PCODE_LOWPWR) &&
                      (mode_ff == tbms_pkg::MODE_ACTIVE);
  assign cmd_active = wr_take && (paddr == tbms_pkg::ADDR_POWER_STATE) &&
                      (wr_pcode == tbms_pkg::PCODE_ACTIVE) &&
                      (mode_ff == tbms_pkg::MODE_LOWPWR);

  // mode sequencing; loss of either supply wins over everything else
  always_comb
  begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      tbms_pkg::MODE_SHUTDOWN:
      begin
        if (io_rise && analog_supply && armed_ff)
          nxt_mode = tbms_pkg::MODE_STARTUP;
      end
      tbms_pkg::MODE_STARTUP:
      begin
        if (wake_cnt_ff == WAKE_LAST)
          nxt_mode = tbms_pkg::MODE_ACTIVE;
      end
      tbms_pkg::MODE_ACTIVE:
      begin
        if (cmd_startup)
          nxt_mode = tbms_pkg::MODE_STARTUP;
        else if (cmd_lowpwr)
          nxt_mode = tbms_pkg::MODE_LOWPWR;
      end
      tbms_pkg::MODE_LOWPWR:
      begin
        if (cmd_startup)
          nxt_mode = tbms_pkg::MODE_STARTUP;
        else if (cmd_active)
          nxt_mode = tbms_pkg::MODE_ACTIVE;
      end
    endcase
    if (supply_lost)
      nxt_mode = tbms_pkg::MODE_SHUTDOWN;
  end

  // mode register; reset lands in shutdown as at first power-up
  always_ff @(posedge clk)
  begin
    if (rst)
      mode_ff <= tbms_pkg::MODE_SHUTDOWN;
    else
      mode_ff <= nxt_mode;
  end

  // startup dwell; the typical figure keeps well inside the maximum
  // cleared in every other mode, so each startup waits the full dwell
  always_ff @(posedge clk)
  begin
    if (rst || mode_ff != tbms_pkg::MODE_STARTUP)
      wake_cnt_ff <= 16'h0000;
    else if (wake_cnt_ff != WAKE_LAST)
      wake_cnt_ff <= wake_cnt_ff + 16'h0001;
  end

  // boost level register: defaults outside active and low power
  // a write during startup is lost while the bank sits at defaults
  always_ff @(posedge clk)
  begin
    if (rst || !regs_live)
      boost_ff <= tbms_pkg::BOOST_RST;
    else if (wr_take && paddr == tbms_pkg::ADDR_BOOST_LEVEL)
      boost_ff <= pwdata[tbms_pkg::BOOST_W-1:0];
  end

  // enable register; no retention through shutdown or startup
  always_ff @(posedge clk)
  begin
    if (rst || !regs_live)
      out_en_ff <= tbms_pkg::OUT_EN_RST;
    else if (wr_take && paddr == tbms_pkg::ADDR_OUTPUT_ENABLE)
      out_en_ff <= pwdata[tbms_pkg::OUTS-1:0];
  end

  // per-output code registers, each written on its own address
  // writing one code never disturbs the other two outputs
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < tbms_pkg::OUTS; i++)
    begin
      if (rst || !regs_live)
        code_ff[i] <= tbms_pkg::CODE_RST;
      else if (wr_take &&
               paddr == tbms_pkg::ADDR_CODE_A + 12'(4 * i))
        code_ff[i] <= pwdata[tbms_pkg::CODE_W-1:0];
    end
  end

  // mode as the power-state field shows it
  // shutdown shows 11, though the bus refuses any read there
  always_comb
  begin
    unique case (mode_ff)
      tbms_pkg::MODE_SHUTDOWN: pcode = tbms_pkg::PCODE_OFF;
      tbms_pkg::MODE_STARTUP: pcode = tbms_pkg::PCODE_STARTUP;
      tbms_pkg::MODE_ACTIVE: pcode = tbms_pkg::PCODE_ACTIVE;
      tbms_pkg::MODE_LOWPWR: pcode = tbms_pkg::PCODE_LOWPWR;
    endcase
  end

  // read data registered in the setup cycle so prdata comes from a flop
  // unmapped reads return zero alongside the error response
  always_ff @(posedge clk)
  begin
    if (rst)
      prdata_ff <= 32'h0000_0000;
    else if (setup_phase && !pwrite)
    begin
      prdata_ff <= 32'h0000_0000;
      unique case (paddr)
        tbms_pkg::ADDR_BOOST_LEVEL:
          prdata_ff[tbms_pkg::BOOST_W-1:0] <= boost_ff;
        tbms_pkg::ADDR_POWER_STATE:
          prdata_ff[tbms_pkg::PSTATE_W-1:0] <= pcode;
        tbms_pkg::ADDR_OUTPUT_ENABLE:
          prdata_ff[tbms_pkg::OUTS-1:0] <= out_en_ff;
        tbms_pkg::ADDR_CODE_A:
          prdata_ff[tbms_pkg::CODE_W-1:0] <= code_ff[0];
        tbms_pkg::ADDR_CODE_B:
          prdata_ff[tbms_pkg::CODE_W-1:0] <= code_ff[1];
        tbms_pkg::ADDR_CODE_C:
          prdata_ff[tbms_pkg::CODE_W-1:0] <= code_ff[2];
        tbms_pkg::ADDR_STATUS:
        begin
          prdata_ff[tbms_pkg::ST_MODE_LSB +: 2] <= mode_ff;
          prdata_ff[tbms_pkg::ST_ARMED_BIT] <= armed_ff;
          prdata_ff[tbms_pkg::ST_BOOST_BIT] <= boost_en_ff;
          prdata_ff[tbms_pkg::ST_DRIVE_LSB +: 3] <= drive_ff;
        end
        tbms_pkg::ADDR_ID:
          prdata_ff <= tbms_pkg::BLOCK_ID;
        default:
          prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = prdata_ff;

  // serial machine held in reset through shutdown and the first startup
  // cycle, which also covers a startup command arriving from active
  always_ff @(posedge clk)
  begin
    if (rst)
      serial_reset_ff <= 1'b1;
    else
      serial_reset_ff <= (nxt_mode == tbms_pkg::MODE_SHUTDOWN) ||
                         (nxt_mode == tbms_pkg::MODE_STARTUP &&
                          mode_ff != tbms_pkg::MODE_STARTUP);
  end

  // boost runs in startup and active only
  // low power drops the boost to save current; registers stay put
  always_ff @(posedge clk)
  begin
    if (rst)
      boost_en_ff <= 1'b0;
    else
      boost_en_ff <= (nxt_mode == tbms_pkg::MODE_STARTUP) ||
                     (nxt_mode == tbms_pkg::MODE_ACTIVE);
  end

  // outputs drive only in active with their own enable set
  // drive follows a mode change one edge late
  always_ff @(posedge clk)
  begin
    if (rst || mode_ff != tbms_pkg::MODE_ACTIVE)
      drive_ff <= 3'h0;
    else
      drive_ff <= out_en_ff;
  end

  // nominal analog levels for the dac and rail models downstream
  always_ff @(posedge clk)
  begin
    if (rst)
      rail_mv_ff <= 16'h0000;
    else
      rail_mv_ff <= level_to_mv(boost_ff);
  end

  // per-output nominal millivolts, one cycle behind the code
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < tbms_pkg::OUTS; i++)
    begin
      if (rst)
        mv_ff[i] <= 16'h0000;
      else
        mv_ff[i] <= code_to_mv(code_ff[i]);
    end
  end

  // the rail margin over the outputs is left to software; nothing here
  // clamps a code that exceeds the programmed rail
  // pins follow the flops directly
  assign boost_enable = boost_en_ff;
  assign boost_level = boost_ff;
  assign boosted_rail_mv = rail_mv_ff;
  assign out_drive = drive_ff;
  assign out_hiz = ~drive_ff;
  assign out_code_a = code_ff[0];
  assign out_code_b = code_ff[1];
  assign out_code_c = code_ff[2];
  assign out_mv_a = mv_ff[0];
  assign out_mv_b = mv_ff[1];
  assign out_mv_c = mv_ff[2];
  assign serial_reset = serial_reset_ff;
  assign power_state = pcode;

endmodule
`default_nettype wire

// file: tbms_properties.sv
// port checker for the mode sequencer
`timescale 1ns/1ps
`default_nettype none
module tbms_properties #(
  parameter int WAKE_CYCLES = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic io_supply,
  input wire logic pslverr,
  input wire logic boost_enable,
  input wire logic [3:0] boost_level,
  input wire logic [2:0] out_drive,
  input wire logic serial_reset,
  input wire logic [1:0] power_state
);
  // two spare cycles for the registered mode decode
  localparam int WMAX = WAKE_CYCLES + 2;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // first cycle of startup
  sequence s_enter;
    power_state == 2'h1 && $past(power_state) != 2'h1;
  endsequence
  property p_io_low;
    !io_supply |=> power_state == 2'h3;
  endproperty
  a_io_low: assert property (p_io_low)
    else $error("io low without shutdown");
  property p_wake;
    s_enter |-> (power_state == 2'h1) [*4] ##[1:WMAX] power_state == 2'h0;
  endproperty
  a_wake: assert property (p_wake)
    else $error("startup did not reach active");
  property p_serial;
    s_enter |-> serial_reset ##1 !serial_reset;
  endproperty
  a_serial: assert property (p_serial)
    else $error("serial reset pulse wrong");
  property p_lp_boost;
    power_state == 2'h2 ##1 power_state == 2'h2 |-> !boost_enable;
  endproperty
  a_lp_boost: assert property (p_lp_boost)
    else $error("boost on in low power");
  property p_hiz;
    (power_state != 2'h0) [*2] |-> out_drive == 3'h0;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("output driven outside active");
  property p_su_boost;
    power_state == 2'h1 ##1 power_state == 2'h1
      |-> boost_enable && boost_level == 4'hB;
  endproperty
  a_su_boost: assert property (p_su_boost)
    else $error("startup boost wrong");
  property p_act_off;
    power_state == 2'h0 && $past(power_state) == 2'h1 |-> out_drive == 3'h0;
  endproperty
  a_act_off: assert property (p_act_off)
    else $error("output on at active entry");
  property p_sd_err;
    psel && penable && power_state == 2'h3 |-> pslverr;
  endproperty
  a_sd_err: assert property (p_sd_err)
    else $error("bus served in shutdown");
  c_enter: cover property (s_enter);
  c_lp: cover property (power_state == 2'h2);
  c_err: cover property (psel && penable && pslverr);
endmodule
bind tbms_sequencer tbms_properties #(.WAKE_CYCLES(WAKE_CYCLES)) u_props (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .io_supply(io_supply), .pslverr(pslverr), .boost_enable(boost_enable),
  .boost_level(boost_level), .out_drive(out_drive),
  .serial_reset(serial_reset), .power_state(power_state)
);
`default_nettype wire

// file: tbms_host.sv
// host controller model: apb master for register and mode commands
`timescale 1ns/1ps
`default_nettype none
module tbms_host (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'hFFF;
    pwdata = 32'hFFFFFFFF;
  end
  // one transfer; mode commands pass here too
  // released lines show inverted values so stale data cannot pass
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// file: tuner_bias_mode_sequencer_tb.sv
// testbench for the mode sequencer
`timescale 1ns/1ps
`default_nettype none
module tuner_bias_mode_sequencer_tb;
  logic clk, rst, analog_supply, io_supply, psel, penable, pwrite;
  logic pready, pslverr, boost_enable, serial_reset, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] boost_level;
  logic [15:0] boosted_rail_mv, out_mv_a;
  logic [2:0] out_drive, out_hiz;
  logic [1:0] power_state;
  int num_checks, n_mismatch, cyc;
  tbms_host host (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  // short wake count keeps the run small
  tbms_sequencer #(.WAKE_CYCLES(8)) dut (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .analog_supply(analog_supply), .io_supply(io_supply),
    .boost_enable(boost_enable), .boost_level(boost_level),
    .boosted_rail_mv(boosted_rail_mv), .out_drive(out_drive),
    .out_hiz(out_hiz), .out_code_a(), .out_code_b(), .out_code_c(),
    .out_mv_a(out_mv_a), .out_mv_b(), .out_mv_c(),
    .serial_reset(serial_reset), .power_state(power_state));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, far above the hundred-odd cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] x,
    input logic [31:0] g);
    num_checks++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [11:0] a);
    host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask
  // bounded wait for a mode, then judged
  task automatic wait_ps(input logic [1:0] s);
    int i;
    i = 0;
    while (power_state !== s && i < 60)
    begin
      step(1);
      i++;
    end
    chk("power_state", {30'h0, s}, {30'h0, power_state});
  endtask
  task automatic t_power_up();
    wait_ps(2'h1);
    wait_ps(2'h0);
    rd(tbms_pkg::ADDR_POWER_STATE);
    chk("mode reg", 32'h0, q);
    rd(tbms_pkg::ADDR_BOOST_LEVEL);
    chk("boost reg", 32'hB, q);
    chk("rail", 32'h5DC0, {16'h0, boosted_rail_mv});
    rd(tbms_pkg::ADDR_OUTPUT_ENABLE);
    chk("enable reg", 32'h0, q);
    chk("hiz", 32'h7, {29'h0, out_hiz});
  endtask
  task automatic t_regs();
    wr(tbms_pkg::ADDR_OUTPUT_ENABLE, 32'h5);
    step(2);
    chk("drive", 32'h5, {29'h0, out_drive});
    chk("hiz", 32'h2, {29'h0, out_hiz});
    wr(tbms_pkg::ADDR_BOOST_LEVEL, 32'hF);
    step(2);
    chk("rail", 32'h6D60, {16'h0, boosted_rail_mv});
    wr(tbms_pkg::ADDR_CODE_A, 32'h7F);
    step(2);
    chk("mv a", 32'h5DC3, {16'h0, out_mv_a});
    rd(tbms_pkg::ADDR_CODE_B);
    chk("code b", 32'h0, q);
    rd(12'h020);
    chk("unmapped err", 32'h1, {31'h0, e});
  endtask
  task automatic t_low_power();
    wr(tbms_pkg::ADDR_POWER_STATE, 32'h2);
    step(2);
    chk("lp mode", 32'h2, {30'h0, power_state});
    chk("lp boost", 32'h0, {31'h0, boost_enable});
    chk("lp drive", 32'h0, {29'h0, out_drive});
    rd(tbms_pkg::ADDR_OUTPUT_ENABLE);
    chk("lp keep", 32'h5, q);
    wr(tbms_pkg::ADDR_POWER_STATE, 32'h3);
    step(2);
    chk("bad cmd", 32'h2, {30'h0, power_state});
    wr(tbms_pkg::ADDR_POWER_STATE, 32'h0);
    step(2);
    chk("wake mode", 32'h0, {30'h0, power_state});
    chk("wake drive", 32'h5, {29'h0, out_drive});
  endtask
  task automatic t_cmd_reset();
    wr(tbms_pkg::ADDR_POWER_STATE, 32'h1);
    wait_ps(2'h1);
    wait_ps(2'h0);
    rd(tbms_pkg::ADDR_OUTPUT_ENABLE);
    chk("reset enable", 32'h0, q);
    rd(tbms_pkg::ADDR_BOOST_LEVEL);
    chk("reset boost", 32'hB, q);
  endtask
  // analog drop, no restart without an io edge, then io cycle
  task automatic t_supply();
    wr(tbms_pkg::ADDR_BOOST_LEVEL, 32'h3);
    @(posedge clk);
    analog_supply <= 1'b0;
    step(2);
    chk("sd mode", 32'h3, {30'h0, power_state});
    rd(tbms_pkg::ADDR_BOOST_LEVEL);
    chk("sd err", 32'h1, {31'h0, e});
    @(posedge clk);
    analog_supply <= 1'b1;
    step(3);
    chk("no rearm", 32'h3, {30'h0, power_state});
    @(posedge clk);
    io_supply <= 1'b0;
    step(2);
    @(posedge clk);
    io_supply <= 1'b1;
    wait_ps(2'h1);
    wait_ps(2'h0);
    rd(tbms_pkg::ADDR_BOOST_LEVEL);
    chk("lost boost", 32'hB, q);
    @(posedge clk);
    io_supply <= 1'b0;
    step(2);
    chk("io drop", 32'h3, {30'h0, power_state});
    chk("io drop boost", 32'h0, {31'h0, boost_enable});
  endtask
  initial
  begin
    rst = 1'b1;
    analog_supply = 1'b1;
    io_supply = 1'b1;
    num_checks = 0;
    n_mismatch = 0;
    cyc = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_power_up();
    t_regs();
    t_low_power();
    t_cmd_reset();
    t_supply();
    finish_test();
  end
endmodule
`default_nettype wire
